// File: core/remote_fraction_regs.sv
// Remote-zone result low byte, limit low bytes and overtemperature limit registers.
//
// Notes on behaviour
// - The result low byte returns the remote reading's fraction in bits 7..4 and zero in 3..0.
// - The result low byte is zero after reset and holds measured data after the first conversion.
// - One fraction step is a sixteenth of a degree, shown as a one in bit 4 with bits 3..0 zero.
// - A word read at command 01h returns the result high byte first, then the result low byte.
// - Both bytes of a word read come from one conversion, by capturing the low byte with the high.
// - Only the result high byte answers a word read; all others are single-byte reads.
// - The high limit low byte has writable fraction bits 7..4, reads zero in 3..0, resets to 0.
// - The low limit low byte has writable fraction bits 7..4, reads zero in 3..0, resets to 0.
// - Any write to a limit register purges and resets that limit's fault queue.
// - The overtemperature limit is a full eight-bit read/write register resetting to 64h.
// - The overtemperature limit is signed two's complement, one degree per step, zero is 00h.
// - The limit high bytes hold whole degrees and join their low bytes to form the full limits.
`timescale 1ns/10ps

module remote_fraction_regs (
  // Clock and reset
  input  wire logic                              clk_sys,
  input  wire logic                              nrst,
  // Register requests from the serial engine
  input  wire remote_fraction_pkg::regReq_t      req,
  output      remote_fraction_pkg::rdResp_t      resp,
  // Converter result
  input  wire remote_fraction_pkg::conversion_t  conv,
  // Whole-degree limit bytes held elsewhere in the unit
  input  wire logic [7:0]                        highLimitInteger,
  input  wire logic [7:0]                        lowLimitInteger,
  // Limits and status toward the comparators
  output      logic [11:0]                       remoteHighLimit,
  output      logic [11:0]                       remoteLowLimit,
  output      logic signed [7:0]                 remoteOvertempLimit,
  output      logic [11:0]                       remoteResult,
  output      logic                              resultValid,
  // Fault queue purge pulses
  output      remote_fraction_pkg::queuePurge_t  purge
);

  typedef struct packed {
    logic [7:0]                       resultInteger;
    logic [3:0]                       resultFraction;
    logic [3:0]                       wordFraction;
    remote_fraction_pkg::wordPhase_t  wordPhase;
    logic [3:0]                       highFraction;
    logic [3:0]                       lowFraction;
    logic [7:0]                       overtempLimit;
    logic                             valid;
    remote_fraction_pkg::rdResp_t     resp;
    remote_fraction_pkg::queuePurge_t purge;
    logic [11:0]                      highLimit;
    logic [11:0]                      lowLimit;
    logic [11:0]                      result;
  } state_t;

  state_t state;
  state_t next_state;

  // Places a four-bit fraction into a byte with the reserved nibble forced to zero.
  function automatic logic [7:0] fractionByte(input logic [3:0] frac);
    fractionByte = {frac, remote_fraction_pkg::RESERVED_ZERO};
  endfunction : fractionByte

  // Takes the writable nibble from a byte written by the host.
  function automatic logic [3:0] writeNibble(input logic [7:0] data);
    logic [7:0] kept;
    kept = data & remote_fraction_pkg::FRACTION_MASK;
    writeNibble = kept[remote_fraction_pkg::FRACTION_LSB +: remote_fraction_pkg::FRACTION_WIDTH];
  endfunction : writeNibble

  // Byte-read decode; command 01h is served here because its byte joins the word read.
  function automatic logic [8:0] byteRead(input logic [7:0] cmd, input state_t s);
    byteRead = {1'b0, remote_fraction_pkg::READ_UNMAPPED};
    unique case (cmd)
      remote_fraction_pkg::CMD_RESULT_INTEGER:  byteRead = {1'b1, s.resultInteger};
      remote_fraction_pkg::CMD_RESULT_FRACTION: byteRead = {1'b1, fractionByte(s.resultFraction)};
      remote_fraction_pkg::CMD_HIGH_FRACTION:   byteRead = {1'b1, fractionByte(s.highFraction)};
      remote_fraction_pkg::CMD_LOW_FRACTION:    byteRead = {1'b1, fractionByte(s.lowFraction)};
      remote_fraction_pkg::CMD_OVERTEMP:        byteRead = {1'b1, s.overtempLimit};
      default:                                  byteRead = {1'b0, remote_fraction_pkg::READ_UNMAPPED};
    endcase
  endfunction : byteRead

  always_comb begin
    logic [8:0] rd;
    rd         = 9'h000;
    next_state = state;

    // Pulses last a single cycle.
    next_state.resp  = '0;
    next_state.purge = '0;

    // A new conversion overwrites the live result; a word read in flight keeps its copy.
    if (conv.done) begin
      next_state.resultInteger  = conv.integerPart;
      next_state.resultFraction = conv.fractionPart;
      next_state.valid          = 1'b1;
    end

    // Host writes to the limit registers.
    if (req.wrStb) begin
      unique case (req.cmd)
        remote_fraction_pkg::CMD_HIGH_FRACTION: begin
          next_state.highFraction = writeNibble(req.wrData);
          next_state.purge.high   = 1'b1;
        end
        remote_fraction_pkg::CMD_LOW_FRACTION: begin
          next_state.lowFraction = writeNibble(req.wrData);
          next_state.purge.low   = 1'b1;
        end
        remote_fraction_pkg::CMD_OVERTEMP: begin
          next_state.overtempLimit  = req.wrData;
          next_state.purge.overtemp = 1'b1;
        end
        // The whole-degree bytes live elsewhere, but their writes still purge here.
        remote_fraction_pkg::CMD_HIGH_INTEGER: next_state.purge.high = 1'b1;
        remote_fraction_pkg::CMD_LOW_INTEGER:  next_state.purge.low  = 1'b1;
        default: begin
        end
      endcase
    end

    // Reads: one kind per cycle, word phases take priority over byte reads.
    if (req.wordHiStb) begin
      next_state.resp.valid = 1'b1;
      if (req.cmd == remote_fraction_pkg::CMD_RESULT_INTEGER) begin
        // Both bytes come from state as it stood, before any conversion landing now.
        next_state.resp.data    = state.resultInteger;
        next_state.wordFraction = state.resultFraction;
        next_state.wordPhase    = remote_fraction_pkg::WORD_PENDING;
      end else begin
        next_state.resp.refused = 1'b1;
        next_state.wordPhase    = remote_fraction_pkg::WORD_IDLE;
      end
    end else if (req.wordLoStb) begin
      next_state.resp.valid = 1'b1;
      if (state.wordPhase == remote_fraction_pkg::WORD_PENDING &&
          req.cmd == remote_fraction_pkg::CMD_RESULT_INTEGER) begin
        next_state.resp.data = fractionByte(state.wordFraction);
      end else begin
        next_state.resp.refused = 1'b1;
      end
      next_state.wordPhase = remote_fraction_pkg::WORD_IDLE;
    end else if (req.rdStb) begin
      rd                      = byteRead(req.cmd, state);
      next_state.resp.valid   = 1'b1;
      next_state.resp.refused = ~rd[8];
      next_state.resp.data    = rd[7:0];
      // A plain byte read abandons any half-finished word read.
      next_state.wordPhase    = remote_fraction_pkg::WORD_IDLE;
    end

    // Full limits and result, registered so every output leaves from a flip-flop.
    next_state.highLimit = {highLimitInteger, next_state.highFraction};
    next_state.lowLimit  = {lowLimitInteger, next_state.lowFraction};
    next_state.result    = {next_state.resultInteger, next_state.resultFraction};
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state.resultInteger  <= remote_fraction_pkg::RESET_RESULT_INTEGER;
      state.resultFraction <= remote_fraction_pkg::RESET_RESULT_FRACTION[7:4];
      state.wordFraction   <= remote_fraction_pkg::RESET_RESULT_FRACTION[7:4];
      state.wordPhase      <= remote_fraction_pkg::WORD_IDLE;
      state.highFraction   <= remote_fraction_pkg::RESET_HIGH_FRACTION[7:4];
      state.lowFraction    <= remote_fraction_pkg::RESET_LOW_FRACTION[7:4];
      state.overtempLimit  <= remote_fraction_pkg::RESET_OVERTEMP;
      state.valid          <= 1'b0;
      state.resp           <= '0;
      state.purge          <= '0;
      state.highLimit      <= 12'h000;
      state.lowLimit       <= 12'h000;
      state.result         <= 12'h000;
    end else begin
      state <= next_state;
    end
  end

  assign resp                = state.resp;
  assign purge               = state.purge;
  assign remoteHighLimit     = state.highLimit;
  assign remoteLowLimit      = state.lowLimit;
  // Signed reading of the same bits; no conversion is applied.
  assign remoteOvertempLimit = signed'(state.overtempLimit);
  assign remoteResult        = state.result;
  assign resultValid         = state.valid;

endmodule : remote_fraction_regs

// File: core/remote_fraction_pkg.sv
// Shared constants and carrier types for the remote-zone fraction and limit registers.
package remote_fraction_pkg;

  // Command bytes seen on the register request port.
  localparam logic [7:0] CMD_RESULT_INTEGER  = 8'h01;
  localparam logic [7:0] CMD_HIGH_INTEGER    = 8'h07;
  localparam logic [7:0] CMD_LOW_INTEGER     = 8'h08;
  localparam logic [7:0] CMD_RESULT_FRACTION = 8'h10;
  localparam logic [7:0] CMD_HIGH_FRACTION   = 8'h13;
  localparam logic [7:0] CMD_LOW_FRACTION    = 8'h14;
  localparam logic [7:0] CMD_OVERTEMP        = 8'h19;

  // Reset values.
  localparam logic [7:0] RESET_RESULT_INTEGER  = 8'h00;
  localparam logic [7:0] RESET_RESULT_FRACTION = 8'h00;
  localparam logic [7:0] RESET_HIGH_FRACTION   = 8'h00;
  localparam logic [7:0] RESET_LOW_FRACTION    = 8'h00;
  localparam logic [7:0] RESET_OVERTEMP        = 8'h64;
  localparam logic [7:0] READ_UNMAPPED         = 8'h00;

  // Fraction field: bits 7..4 carry sixteenths of a degree, bits 3..0 read zero.
  localparam int         FRACTION_WIDTH = 4;
  localparam int         FRACTION_LSB   = 4;
  localparam logic [7:0] FRACTION_MASK  = 8'hf0;
  localparam logic [3:0] RESERVED_ZERO  = 4'h0;

  // One register request from the serial engine, same clock.
  typedef struct packed {
    logic [7:0] cmd;
    logic       wrStb;
    logic [7:0] wrData;
    logic       rdStb;
    logic       wordHiStb;
    logic       wordLoStb;
  } regReq_t;

  // Answer to a read, valid for one cycle.
  typedef struct packed {
    logic       valid;
    logic       refused;
    logic [7:0] data;
  } rdResp_t;

  // Result delivered by the converter at the end of a conversion.
  typedef struct packed {
    logic       done;
    logic [7:0] integerPart;
    logic [3:0] fractionPart;
  } conversion_t;

  // Fault queue purge pulses, one per remote limit.
  typedef struct packed {
    logic high;
    logic low;
    logic overtemp;
  } queuePurge_t;

  typedef enum logic [0:0] {WORD_IDLE, WORD_PENDING} wordPhase_t;

endpackage : remote_fraction_pkg

// File: sim/remote_fraction_regs_assertions.sv
// Concurrent checks on the ports of the remote fraction and limit registers.
`timescale 1ns/10ps
module remote_fraction_regs_checker (
  // Clock and reset
  input wire logic                              clk_sys,
  input wire logic                              nrst,
  // Watched ports
  input wire remote_fraction_pkg::regReq_t      req,
  input wire remote_fraction_pkg::rdResp_t      resp,
  input wire remote_fraction_pkg::conversion_t  conv,
  input wire logic [7:0]                        highLimitInteger,
  input wire logic [7:0]                        lowLimitInteger,
  input wire logic [11:0]                       remoteHighLimit,
  input wire logic [11:0]                       remoteLowLimit,
  input wire logic signed [7:0]                 remoteOvertempLimit,
  input wire logic [11:0]                       remoteResult,
  input wire logic                              resultValid,
  input wire remote_fraction_pkg::queuePurge_t  purge
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  wire       rdAny  = req.rdStb | req.wordHiStb | req.wordLoStb;
  wire       wrHigh = req.wrStb && req.cmd == 8'h13;
  wire       wrLow  = req.wrStb && req.cmd == 8'h14;
  wire       wrOt   = req.wrStb && req.cmd == 8'h19;
  wire [3:0] wrFrac = req.wrData[7:4];
  property p_answer; rdAny |=> resp.valid; endproperty
  a_answer: assert property (p_answer) else $error("read not answered");
  property p_quiet; !rdAny |=> !resp.valid; endproperty
  a_quiet: assert property (p_quiet) else $error("answer without read");
  property p_zero_low;
    resp.valid && $past(req.cmd) inside {8'h10, 8'h13, 8'h14} |-> resp.data[3:0] == 4'h0;
  endproperty
  a_zero_low: assert property (p_zero_low) else $error("reserved bits set");
  property p_conv;
    conv.done |=> resultValid && remoteResult == {$past(conv.integerPart), $past(conv.fractionPart)};
  endproperty
  a_conv: assert property (p_conv) else $error("result not captured");
  property p_purge; !req.wrStb |=> purge == 3'b000; endproperty
  a_purge: assert property (p_purge) else $error("purge without write");
  property p_high; wrHigh |=> purge.high && remoteHighLimit[3:0] == $past(wrFrac); endproperty
  a_high: assert property (p_high) else $error("high limit fraction wrong");
  property p_low; wrLow |=> purge.low && remoteLowLimit[3:0] == $past(wrFrac); endproperty
  a_low: assert property (p_low) else $error("low limit fraction wrong");
  property p_ot; wrOt |=> purge.overtemp && remoteOvertempLimit == $past(req.wrData); endproperty
  a_ot: assert property (p_ot) else $error("overtemp limit wrong");
  // The limit flops hold zero through reset, so the follow check starts one edge after release.
  property p_int; $past(nrst) |=> remoteLowLimit[11:4] == $past(lowLimitInteger); endproperty
  a_int: assert property (p_int) else $error("low limit integer wrong");
  property p_word; req.wordHiStb && req.cmd != 8'h01 |=> resp.refused; endproperty
  a_word: assert property (p_word) else $error("word read not refused");
  c_write: cover property (wrHigh);
  c_word: cover property (req.wordLoStb && req.cmd == 8'h01);
  c_conv: cover property (conv.done);
endmodule : remote_fraction_regs_checker
bind remote_fraction_regs remote_fraction_regs_checker u_chk (.clk_sys, .nrst, .req, .resp,
  .conv, .highLimitInteger, .lowLimitInteger, .remoteHighLimit, .remoteLowLimit,
  .remoteOvertempLimit, .remoteResult, .resultValid, .purge);

// File: sim/smbus_host_model.sv
// Host-side model issuing byte writes, byte reads and word reads.
`timescale 1ns/10ps
module smbus_host_model (
  // Clock
  input wire logic                          clk_sys,
  // Register port
  output     remote_fraction_pkg::regReq_t  req,
  input wire remote_fraction_pkg::rdResp_t  resp
);
  initial req = '0;
  // Kind 0 writes, 1 reads a byte, 2 and 3 fetch the two bytes of a word.
  task automatic xfer(input int k, input logic [7:0] c, input logic [7:0] w,
                      output logic [7:0] d, output logic v, output logic rf);
    @(posedge clk_sys);
    req <= '{cmd: c, wrStb: k == 0, wrData: w, rdStb: k == 1,
             wordHiStb: k == 2, wordLoStb: k == 3};
    @(posedge clk_sys);
    // Released lines show a changed value so a stale read cannot pass.
    req <= '{cmd: ~c, wrData: ~w, default: 1'b0};
    #1;
    d = resp.data;
    v = resp.valid;
    rf = resp.refused;
  endtask : xfer
endmodule : smbus_host_model

// File: sim/remote_zone_fraction_limit_regs_tb.sv
// Self-checking bench for the remote fraction and limit registers.
`timescale 1ns/10ps
`define CHK(a, b) chk(12'(a), 12'(b))
module remote_zone_fraction_limit_regs_tb;
  logic                              clk_sys = 1'b0;
  logic                              nrst = 1'b0;
  logic [7:0]                        highInt = 8'h50;
  logic [7:0]                        lowInt = 8'h00;
  remote_fraction_pkg::conversion_t  conv = '0;
  remote_fraction_pkg::regReq_t      req;
  remote_fraction_pkg::rdResp_t      resp;
  remote_fraction_pkg::queuePurge_t  purge;
  logic [11:0]                       hiLim, loLim, result;
  logic signed [7:0]                 otLim;
  logic                              resValid, v, rf;
  logic [7:0]                        d;
  int                                n_errors = 0;
  int                                comparisons = 0;
  always #4 clk_sys = ~clk_sys;
  remote_fraction_regs dut (.clk_sys, .nrst, .req, .resp, .conv, .highLimitInteger(highInt),
    .lowLimitInteger(lowInt), .remoteHighLimit(hiLim), .remoteLowLimit(loLim),
    .remoteOvertempLimit(otLim), .remoteResult(result), .resultValid(resValid), .purge);
  smbus_host_model host (.clk_sys, .req, .resp);
  task automatic chk(input logic [11:0] a, input logic [11:0] b);
    comparisons++;
    if (a !== b) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, a, b);
    end
  endtask : chk
  task automatic rd(int k, logic [7:0] c, logic [7:0] e, logic r);
    host.xfer(k, c, 8'h00, d, v, rf);
    `CHK(v, 1);
    `CHK(rf, r);
    `CHK(d, e);
  endtask : rd
  task automatic wr(logic [7:0] c, logic [7:0] w, logic [2:0] p);
    host.xfer(0, c, w, d, v, rf);
    `CHK(purge, p);
  endtask : wr
  task automatic cv(logic [7:0] i, logic [3:0] f);
    @(posedge clk_sys) conv <= {1'b1, i, f};
    @(posedge clk_sys) conv.done <= 1'b0;
  endtask : cv
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  initial begin
    #100000;
    n_errors++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    lowInt <= 8'hf6;
    rd(1, 8'h10, 8'h00, 0);
    rd(1, 8'h13, 8'h00, 0);
    rd(1, 8'h14, 8'h00, 0);
    rd(1, 8'h19, 8'h64, 0);
    rd(1, 8'h55, 8'h00, 1);
    `CHK(resValid, 0);
    $display("test reset values done");
    wr(8'h13, 8'hab, 3'b100);
    rd(1, 8'h13, 8'ha0, 0);
    wr(8'h14, 8'h5f, 3'b010);
    rd(1, 8'h14, 8'h50, 0);
    wr(8'h19, 8'h9c, 3'b001);
    rd(1, 8'h19, 8'h9c, 0);
    wr(8'h07, 8'h12, 3'b100);
    wr(8'h08, 8'h34, 3'b010);
    `CHK(otLim == -8'sd100, 1);
    `CHK(hiLim, 12'h50a);
    `CHK(loLim, 12'hf65);
    $display("test limit writes done");
    cv(8'h3c, 4'h1);
    rd(1, 8'h10, 8'h10, 0);
    `CHK(result, 12'h3c1);
    rd(2, 8'h01, 8'h3c, 0);
    cv(8'h7f, 4'hf);
    rd(3, 8'h01, 8'h10, 0);
    rd(2, 8'h01, 8'h7f, 0);
    rd(3, 8'h01, 8'hf0, 0);
    rd(2, 8'h13, 8'h00, 1);
    rd(3, 8'h01, 8'h00, 1);
    $display("test word reads done");
    @(posedge clk_sys) nrst <= 1'b0;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(1, 8'h19, 8'h64, 0);
    rd(1, 8'h10, 8'h00, 0);
    $display("test second reset done");
    give_verdict();
  end
endmodule : remote_zone_fraction_limit_regs_tb
